//--- logic/gpio_port_params.svh
// Purpose: offsets, field positions, reset values of the six-bit I/O port
// Assumes: AHB-Lite word registers, 32-bit data
// Notes:   all offsets are byte addresses
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH

`define OFS_PORT_PIN_DATA      8'h00
`define OFS_PORT_DIRECTION     8'h04
`define OFS_PULLUP_ENABLE      8'h08
`define OFS_CHANGE_IRQ_ENABLE  8'h0c
`define OFS_ANALOG_SELECT      8'h10
`define OFS_IRQ_CONTROL        8'h14
`define OFS_OPTION             8'h18

`define PORT_W                 6
`define DIR_MASK               6'h37
`define DIR_RESET              6'h3f
`define PULLUP_RESET           6'h3f
`define CHANGE_EN_RESET        6'h00
`define ANALOG_MASK            6'h17
`define ANALOG_RESET           6'h17
`define BIT_MASTER_CLEAR       3
`define BIT_TIMER_CLK          2
`define FLAG_BIT               0
`define IRQ_EN_BIT             3
`define PULLUP_DIS_BIT         7

`endif

//--- logic/gpio_port_pkg.sv
// Purpose: types of the six-bit I/O port
// Assumes: used with gpio_port_params.svh
// Notes:   data phase state of the bus slave
package gpio_port_pkg;
  typedef enum logic {
    ph_idle,
    ph_data
  } bus_phase_t;
  typedef logic [5:0] port_vec_t;
endpackage

//--- logic/gpio_port.sv
// Purpose: six-pin I/O port, bidirectional except input-only bit three, with change detect, AHB-Lite slave
// Assumes: pins synchronous-ish, sampled through two flops on hclk
// Notes:   zero wait states, response always OKAY
// Summary of operation
// (R1) Direction one disables the pin driver
// (R2) Direction zero drives pin from latch
// (R3) Data read gives pins, write hits latch
// (R4) Port write is read-modify-write
// (R5) Analog-selected pins read zero
// (R6) Analog select leaves digital output alone
// (R7) Software keeps analog pins as inputs
// (R8) Per-bit pull-up enables, bits five to zero
// (R9) Pull-up off while pin is output
// (R10) Global disable gates pull-ups, set at power-on
// (R11) Master clear enable forces bit three pull-up
// (R12) Per-bit change enables, cleared at power-on
// (R13) Mismatch versus last read sets flag
// (R14) Global change enable gates the interrupt
// (R15) Mismatch keeps setting flag until port access
// (R16) Last-read latch survives master clear, brown-out
// (R17) Change coinciding with read still sets flag
// (R18) Change condition wakes from sleep
// (R19) Direction bit three reads one, top zero
// (R20) Timer clock follows pad regardless of direction; code takes latch bit two when output
// (R21) Analog bits four, two-zero; pull-up unaffected
// (R22) Change flag at bit zero, sticky
// (R23) Pin inputs pass two-flop synchroniser
`timescale 1ns/100ps
`include "gpio_port_params.svh"

module gpio_port
  import gpio_port_pkg::*;
(
  input  wire logic        hclk,                 // Core clock, 50 MHz
  input  wire logic        hresetn,              // Power-on reset, async, low
  input  wire logic        warm_resetn,          // Master clear / brown-out, async, low
  input  wire logic        master_clear_pin_enable, // Configuration strap
  input  wire logic        hsel,                 // Slave select
  input  wire logic [31:0] haddr,                // Byte address
  input  wire logic [1:0]  htrans,               // Transfer type
  input  wire logic        hwrite,               // Write when high
  input  wire logic [2:0]  hsize,                // Transfer size
  input  wire logic        hready,               // Bus ready in
  input  wire logic [31:0] hwdata,               // Write data
  output logic      [31:0] hrdata,               // Read data
  output logic             hreadyout,            // Always ready
  output logic             hresp,                // Always OKAY
  input  wire logic [5:0]  pin_in,               // Pad input levels
  output logic      [5:0]  pin_out,              // Pad output levels
  output logic      [5:0]  pin_oe,               // Pad drive enable, high drives
  output logic      [5:0]  pullup_on,            // Weak pull-up active
  output logic             timer_clock_input,    // Timer clock from bit two, pad when input, latch when output
  output logic             pin_change_irq,       // Change interrupt to processor
  output logic             wake_request          // Wake from sleep
);

  port_vec_t  sync1_r;
  port_vec_t  sync2_r;
  port_vec_t  latch_r;
  port_vec_t  dir_r;
  port_vec_t  pullup_en_r;
  port_vec_t  change_en_r;
  port_vec_t  analog_r;
  port_vec_t  last_read_r;
  logic       flag_r;
  logic       irq_en_r;
  logic       pullup_dis_r;
  bus_phase_t phase_r;
  logic [7:0] addr_r;
  logic       wr_r;
  logic       rd_r;
  port_vec_t  pins_digital;
  port_vec_t  mismatch;
  logic       port_access;
  logic       addr_ok;

  // Two-flop synchroniser on pad inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end else begin
      sync1_r <= pin_in;                         // R23
      sync2_r <= sync1_r;                        // R23
    end
  end

  // Digital view of the pins, analog ones read zero
  assign pins_digital = sync2_r & ~analog_r;    // R5

  // Address phase capture, zero wait states
  assign addr_ok = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= ph_idle;
      addr_r  <= 8'h00;
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
    end else begin
      phase_r <= addr_ok ? ph_data : ph_idle;
      addr_r  <= haddr[7:0];
      wr_r    <= addr_ok && hwrite;
      rd_r    <= addr_ok && !hwrite;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Any read or write of the data register ends the mismatch
  assign port_access = (phase_r == ph_data) && (addr_r == `OFS_PORT_PIN_DATA); // R15

  // Output latch, writes apply to the latch not the pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_r <= 6'h00;
    end else if (wr_r && addr_r == `OFS_PORT_PIN_DATA) begin
      latch_r <= hwdata[5:0];                    // R3 R4
    end
  end

  // Control registers, power-on values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dir_r        <= `DIR_RESET;
      pullup_en_r  <= `PULLUP_RESET;
      change_en_r  <= `CHANGE_EN_RESET;          // R12
      analog_r     <= `ANALOG_RESET;
      irq_en_r     <= 1'b0;
      pullup_dis_r <= 1'b1;                      // R10
    end else if (wr_r) begin
      unique case (addr_r)
        `OFS_PORT_DIRECTION:    dir_r       <= hwdata[5:0] | ~`DIR_MASK; // R19
        `OFS_PULLUP_ENABLE:     pullup_en_r <= hwdata[5:0];              // R8
        `OFS_CHANGE_IRQ_ENABLE: change_en_r <= hwdata[5:0];              // R12
        `OFS_ANALOG_SELECT:     analog_r    <= hwdata[5:0] & `ANALOG_MASK; // R21
        `OFS_IRQ_CONTROL:       irq_en_r    <= hwdata[`IRQ_EN_BIT];
        `OFS_OPTION:            pullup_dis_r <= hwdata[`PULLUP_DIS_BIT];
        default: ;
      endcase
    end
  end

  // Last-read latch: cleared only by power-on, survives master clear and brown-out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_read_r <= 6'h00;
    end else if (port_access) begin
      last_read_r <= pins_digital;               // R16
    end
  end

  // Mismatch of enabled pins against last-read value
  assign mismatch = (pins_digital ^ last_read_r) & change_en_r; // R13

  // Sticky change flag; set beats clear and a coinciding read
  always_ff @(posedge hclk or negedge warm_resetn) begin
    if (!warm_resetn) begin
      flag_r <= 1'b0;
    end else if (|mismatch) begin
      flag_r <= 1'b1;                            // R13 R15 R17 R22
    end else if (wr_r && addr_r == `OFS_IRQ_CONTROL && !hwdata[`FLAG_BIT]) begin
      flag_r <= 1'b0;                            // R22
    end
  end

  // Read data, decoded combinationally in the data phase
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_r) begin
      unique case (addr_r)
        `OFS_PORT_PIN_DATA:     hrdata[5:0] = pins_digital;              // R3 R5
        `OFS_PORT_DIRECTION:    hrdata[5:0] = dir_r | ~`DIR_MASK;        // R19
        `OFS_PULLUP_ENABLE:     hrdata[5:0] = pullup_en_r;
        `OFS_CHANGE_IRQ_ENABLE: hrdata[5:0] = change_en_r;
        `OFS_ANALOG_SELECT:     hrdata[5:0] = analog_r;
        `OFS_IRQ_CONTROL: begin
          hrdata[`FLAG_BIT]   = flag_r;
          hrdata[`IRQ_EN_BIT] = irq_en_r;
        end
        `OFS_OPTION:            hrdata[`PULLUP_DIS_BIT] = pullup_dis_r;
        default: ;
      endcase
    end
  end

  // Pad drivers, analog select plays no part
  assign pin_out = latch_r;                      // R2 R6
  assign pin_oe  = ~dir_r & `DIR_MASK;           // R1 R2

  // Weak pull-ups
  always_comb begin
    pullup_on = pullup_en_r & dir_r & {6{!pullup_dis_r}}; // R9 R10 R21
    if (master_clear_pin_enable) begin
      pullup_on[`BIT_MASTER_CLEAR] = 1'b1;       // R11
    end
  end

  // Timer clock sees the synchronised pad when input, the latch when output
  assign timer_clock_input = dir_r[`BIT_TIMER_CLK] ? sync2_r[`BIT_TIMER_CLK]
                                                   : latch_r[`BIT_TIMER_CLK]; // R20

  // Interrupt and wake
  assign pin_change_irq = flag_r & irq_en_r;     // R14
  assign wake_request   = flag_r & irq_en_r;     // R18

endmodule

//--- bench/gpio_port_monitor.sv
// Purpose: port-level checks of the I/O port
// Assumes: one clock domain, bound to the top module
// Notes:   bus offsets come from the shared header
`timescale 1ns/100ps
`include "gpio_port_params.svh"
module gpio_port_monitor (
  input wire logic        hclk,                    // Clock
  input wire logic        hresetn,                 // Reset, low
  input wire logic        warm_resetn,             // Flag reset, low
  input wire logic        master_clear_pin_enable, // Strap
  input wire logic        hsel,                    // Select
  input wire logic [31:0] haddr,                   // Address
  input wire logic [1:0]  htrans,                  // Transfer type
  input wire logic        hwrite,                  // Write
  input wire logic        hready,                  // Ready in
  input wire logic [31:0] hrdata,                  // Read data
  input wire logic [5:0]  pin_oe,                  // Drive enables
  input wire logic [5:0]  pullup_on,               // Pull-ups
  input wire logic        pin_change_irq,          // Interrupt
  input wire logic        wake_request             // Wake
);
  // Requests taken at this edge
  wire logic rtk = hsel && hready && htrans[1] && !hwrite;
  wire logic wtk = hsel && hready && htrans[1] && hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_OE3: assert property (!pin_oe[3]) else $error("bit 3 driven");
  AST_PU_OUT: assert property ((pullup_on & pin_oe) == 6'h00) else $error("pull-up on output");
  AST_PU3_FORCE: assert property (master_clear_pin_enable |-> pullup_on[3]) else $error("pu3 off");
  AST_WAKE: assert property (pin_change_irq == wake_request) else $error("wake differs");
  AST_DIR_RD: assert property (rtk && haddr[7:0] == `OFS_PORT_DIRECTION
    |=> hrdata[31:6] == 26'h0 && hrdata[3]) else $error("direction read");
  AST_ANA_RD: assert property (rtk && haddr[7:0] == `OFS_ANALOG_SELECT
    |=> (hrdata & ~32'h17) == 32'h0) else $error("analog read");
  AST_PU_RD: assert property (rtk && haddr[7:0] == `OFS_PULLUP_ENABLE
    |=> hrdata[31:6] == 26'h0) else $error("pull-up read");
  AST_STICKY: assert property (disable iff (!hresetn || !warm_resetn)
    $fell(pin_change_irq) |-> $past(wtk, 2)) else $error("flag fell alone");
  cover property (pin_change_irq);
  cover property (rtk && haddr[7:0] == `OFS_PORT_DIRECTION);
  cover property (master_clear_pin_enable && pullup_on[3]);
endmodule
bind gpio_port gpio_port_monitor mon_u (.hclk, .hresetn, .warm_resetn,
  .master_clear_pin_enable, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .pin_oe, .pullup_on, .pin_change_irq, .wake_request);

//--- bench/pad_model.sv
// Purpose: board circuitry on the six pads
// Assumes: a driven pad follows the port, else the board
// Notes:   an undriven pad with no pull-up toggles each cycle
`timescale 1ns/100ps
module pad_model (
  input  wire logic       clk,       // Clock
  input  wire logic [5:0] pin_out,   // Port levels
  input  wire logic [5:0] pin_oe,    // Port drives
  input  wire logic [5:0] pullup_on, // Pull-ups
  input  wire logic [5:0] ext_val,   // Board levels
  input  wire logic [5:0] ext_en,    // Board drives
  output logic      [5:0] pin_in     // Pad levels
);
  logic [5:0] flt_r = 6'h15; // Floating pattern
  // Undriven pad without pull-up never holds a level
  always_ff @(posedge clk) begin
    flt_r <= ~flt_r;
  end
  // Resolve each pad
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pullup_on | flt_r));
endmodule

//--- bench/gpio_port_tb.sv
// Purpose: self-checking bench of the I/O port
// Assumes: answer read at the edge ending the data phase
// Notes:   model array m holds registers by word index
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module gpio_port_tb;
  logic        hclk = 0, hresetn = 0, warm_n = 0, mce = 0, hsel = 0, hwrite = 0;
  logic        hreadyout, hresp, tci, irq, wake;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, seed = 32'h56d20471;
  logic [5:0]  ext = 0, pin_in, pin_out, pin_oe, pullup_on;
  int          error_cnt = 0, num_checks = 0, cyc = 0, i, j, flag = 0, last = 0;
  int          msk[8] = '{63, 'h37, 63, 63, 'h17, 8, 'h80, 0};
  int          m[8] = '{0, 'h3f, 'h3f, 0, 'h17, 0, 'h80, 0};
  gpio_port dut_u (.hclk, .hresetn, .warm_resetn(warm_n), .master_clear_pin_enable(mce),
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata,
    .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe, .pullup_on, .timer_clock_input(tci),
    .pin_change_irq(irq), .wake_request(wake));
  pad_model pad_u (.clk(hclk), .pin_out, .pin_oe, .pullup_on, .ext_val(ext),
    .ext_en(6'h3f), .pin_in);
  // Clock and hang guard
  always #10 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Pad levels, digital view masks analog pins
  function automatic int pad(bit dg);
    return (~m[1] & m[0] | m[1] & ext) & (dg ? ~m[4] & 63 : 63);
  endfunction
  // One bus transfer, checked or recorded in the model
  task automatic xfer(bit w, int a, logic [31:0] d);
    int rm;
    rm = (a == 20) ? 9 : (a == 24) ? 'h80 : -1;
    if (a == 0) last = pad(1);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= 32'(a);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    `CHK(hresp, 1'b0)
    if (!w) `CHK(hrdata & rm, (a == 0 ? pad(1) : m[a / 4] | (a == 20 ? flag : 0)) & rm)
    else m[a / 4] = d & msk[a / 4] | (a == 4 ? 8 : 0);
  endtask
  task automatic pins();
    `CHK(pin_oe, 6'(~m[1]))
    `CHK(pin_out, 6'(m[0]))
    `CHK(pullup_on, 6'((m[6] ? 0 : m[2] & m[1]) | (mce ? 8 : 0)))
    `CHK(tci, 1'(pad(0) >> 2))
    `CHK(irq, 1'(flag & m[5] >> 3))
    `CHK(wake, 1'(flag & m[5] >> 3))
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset values, then random configurations with pin changes
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    warm_n <= 1;
    @(posedge hclk);
    for (j = 0; j < 32; j += 4) xfer(0, j, 0);
    for (i = 0; i < 12; i++) begin
      for (j = 0; j < 32; j += 4) xfer(1, j, (j == 16 && !i[0]) ? rnd() & m[1] : rnd());
      mce <= seed[9];
      ext <= seed[5:0];
      repeat (5) @(posedge hclk);
      xfer(0, 0, 0);
      xfer(1, 20, seed & 8);
      flag = 0;
      repeat (3) @(posedge hclk);
      pins();
      ext <= 6'(rnd());
      repeat (5) @(posedge hclk);
      flag = |((pad(1) ^ last) & m[3]);
      if (i[0]) begin
        warm_n <= 0;
        @(posedge hclk);
        warm_n <= 1;
        repeat (3) @(posedge hclk);
      end
      pins();
      for (j = 0; j < 32; j += 4) xfer(0, j, 0);
    end
    wrap_up();
  end
endmodule
